// file: hdl/fsp_pkg.sv
// constants, register indices and state type for flash self-programming
// ----------------------------------------------------------------------------
// Notes on behaviour
// - software cannot set the enabled flag
// - clearing enabled flag blocks erase and write
// - op select: 000 write, 001 erase, 011 read
// - 110 selects unlock; other codes do nothing
// - trigger starts timer; timeout clears the trigger
// - unlock pattern 00,0D,C3 low; 04,09,40 high
// - flag sets only on full correct pattern
// - program start launches op, clears when done
// - reads only start while read gate is set
// - read start loads one word into word0
// - cpu stalls while a launched op runs
// - key 55H written generates whole-chip reset
// - buffer clear start clears buffer, self-clears
// - reserved bit is written and reads back; upper bits read zero
// - word address is fourteen bits, 8 plus 6
// - word0 low write only stores the byte
// - word0 high write loads buffer once unlocked, bumps address
// - address increment stops at page end 11111b
// - finished write process clears the buffer
// - all registers reset to zero
// ----------------------------------------------------------------------------
package fsp_pkg;

  // --------------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------------
  localparam int unsigned ADDR_W     = 14;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned REG_IDX_W  = 4;
  localparam int unsigned PAGE_WORDS = 32;
  localparam int unsigned WIDX_W     = 5;
  localparam int unsigned DATA_WORDS = 4;

  // --------------------------------------------------------------------------
  // register indices
  // --------------------------------------------------------------------------
  localparam logic [3:0] REG_FLASH_CONTROL  = 4'h0;
  localparam logic [3:0] REG_CHIP_RESET_KEY = 4'h1;
  localparam logic [3:0] REG_BUFFER_CONTROL = 4'h2;
  localparam logic [3:0] REG_ADDR_LOW       = 4'h3;
  localparam logic [3:0] REG_ADDR_HIGH      = 4'h4;
  localparam logic [3:0] REG_DATA0_LOW      = 4'h5; // words follow lo/hi

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int unsigned CTL_ENABLED_BIT = 7;
  localparam int unsigned CTL_MODE_LSB    = 4;
  localparam int unsigned CTL_TRIGGER_BIT = 3;
  localparam int unsigned CTL_PROGRAM_BIT = 2;
  localparam int unsigned CTL_GATE_BIT    = 1;
  localparam int unsigned CTL_READ_BIT    = 0;
  localparam int unsigned BUF_CLEAR_BIT   = 0;
  localparam int unsigned BUF_RSVD_BIT    = 1;
  localparam int unsigned PAGE_LSB        = 5;

  // --------------------------------------------------------------------------
  // codes, values and timing
  // --------------------------------------------------------------------------
  localparam logic [2:0] MODE_WRITE  = 3'h0;
  localparam logic [2:0] MODE_ERASE  = 3'h1;
  localparam logic [2:0] MODE_READ   = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;
  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [7:0] CHIP_RESET_KEY = 8'h55;
  localparam logic [4:0] LAST_WORD   = 5'h1f;
  localparam logic [7:0] UNLOCK_LOW  [3] = '{8'h00, 8'h0d, 8'hc3};
  localparam logic [7:0] UNLOCK_HIGH [3] = '{8'h04, 8'h09, 8'h40};
  localparam int unsigned UNLOCK_TIME_CYCLES = 64; // system clocks

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ERASE,
    ST_PLOAD,
    ST_PWAIT,
    ST_PCLEAR,
    ST_READ
  } fsp_state_t;

endpackage

// file: hdl/fsp_write_buffer.sv
// page write buffer with a sweeping clear process
module fsp_write_buffer #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned WIDTH = 16,
  parameter int unsigned IDX_W = 5
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             wrEn,
  input  wire logic [IDX_W-1:0] wrIdx,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic             clrStart,
  input  wire logic [IDX_W-1:0] rdIdx,
  output logic      [WIDTH-1:0] rdData,
  output logic                  clrBusy,
  output logic                  clrDone
);

  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [IDX_W-1:0] clrIdx_reg;
  logic             clrBusy_reg;
  logic             clrDone_reg;

  // clear sweep: one word per clock, so a clear takes DEPTH cycles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clrBusy_reg <= 1'b0;
      clrIdx_reg  <= '0;
      clrDone_reg <= 1'b0;
    end else begin
      clrDone_reg <= 1'b0;
      if (!clrBusy_reg && clrStart) begin
        clrBusy_reg <= 1'b1;
        clrIdx_reg  <= '0;
      end else if (clrBusy_reg) begin
        clrIdx_reg <= clrIdx_reg + 1'b1;
        if (clrIdx_reg == LAST_IDX) begin
          clrBusy_reg <= 1'b0;
          clrDone_reg <= 1'b1;
        end
      end
    end
  end

  // storage; loads are dropped during a clear so it ends truly blank
  always_ff @(posedge clk) begin
    if (clrBusy_reg) begin
      mem[clrIdx_reg] <= '0;
    end else if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
  end

  assign rdData  = mem[rdIdx];
  assign clrBusy = clrBusy_reg;
  assign clrDone = clrDone_reg;

endmodule

// file: hdl/fsp_ctrl.sv
// flash self-programming controller: registers, unlock, erase/program/read
module fsp_ctrl import fsp_pkg::*; #(
  parameter int unsigned UNLOCK_CYCLES = UNLOCK_TIME_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [3:0]        regAddr,
  input  wire logic              regWrite,
  input  wire logic [7:0]        regWdata,
  output logic      [7:0]        regRdata,
  output logic                   cpuStall,
  output logic                   chipResetReq,
  output logic                   flashErase,
  output logic                   flashProgram,
  output logic                   flashRead,
  output logic      [ADDR_W-1:0] flashAddr,
  output logic      [WORD_W-1:0] flashWdata,
  input  wire logic              flashDone,
  input  wire logic [WORD_W-1:0] flashRdata
);

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  localparam int unsigned TMR_W = $clog2(UNLOCK_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(UNLOCK_CYCLES - 1);

  fsp_state_t        state_reg;
  logic              enabled_reg;
  logic [2:0]        mode_reg;
  logic              trigger_reg;
  logic [TMR_W-1:0]  timer_reg;
  logic [5:0]        seen_reg;
  logic              gate_reg;
  logic [7:0]        key_reg;
  logic              rsvd_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0]        dataLo_reg [DATA_WORDS];
  logic [7:0]        dataHi_reg [DATA_WORDS];
  logic [WIDX_W-1:0] wordIdx_reg;
  logic [7:0]        regRdata_reg;
  logic              cpuStall_reg;
  logic              chipResetReq_reg;
  logic              flashErase_reg;
  logic              flashProgram_reg;
  logic              flashRead_reg;
  logic [ADDR_W-1:0] flashAddr_reg;
  logic [WORD_W-1:0] flashWdata_reg;

  logic              wrCtl, wrKey, wrBuf, wrAddrL, wrAddrH;
  logic [DATA_WORDS-1:0] wrLo, wrHi;
  logic [2:0]        newMode;
  logic              patternOk, unlockOk;
  logic              launchErase, launchProg, launchRead;
  logic              readDone, progLast, opBusy;
  logic              bufWrEn, bufClrStart, bufBusy, bufDone;
  logic [WORD_W-1:0] bufRdData;
  logic [7:0]        rdMux;

  // --------------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------------
  function automatic logic regHit(input logic we, input logic [3:0] a,
                                  input logic [3:0] idx);
    return we && (a == idx);
  endfunction

  function automatic logic isMode(input logic [2:0] m, input logic [2:0] c);
    return m == c;
  endfunction

  // register write strobes
  assign wrCtl   = regHit(regWrite, regAddr, REG_FLASH_CONTROL);
  assign wrKey   = regHit(regWrite, regAddr, REG_CHIP_RESET_KEY);
  assign wrBuf   = regHit(regWrite, regAddr, REG_BUFFER_CONTROL);
  assign wrAddrL = regHit(regWrite, regAddr, REG_ADDR_LOW);
  assign wrAddrH = regHit(regWrite, regAddr, REG_ADDR_HIGH);
  assign newMode = regWdata[CTL_MODE_LSB +: 3];

  for (genvar n = 0; n < DATA_WORDS; n++) begin : g_strobe
    assign wrLo[n] = regHit(regWrite, regAddr, 4'(REG_DATA0_LOW + 2 * n));
    assign wrHi[n] = regHit(regWrite, regAddr, 4'(REG_DATA0_LOW + 2 * n + 1));
  end

  // --------------------------------------------------------------------------
  // unlock sequence
  // --------------------------------------------------------------------------
  // pattern compare on words one to three
  always_comb begin
    patternOk = 1'b1;
    for (int w = 1; w < DATA_WORDS; w++) begin
      if (dataLo_reg[w] != UNLOCK_LOW[w-1] ||
          dataHi_reg[w] != UNLOCK_HIGH[w-1]) begin
        patternOk = 1'b0;
      end
    end
  end

  // all six bytes rewritten in the window and correct
  assign unlockOk = trigger_reg && isMode(mode_reg, MODE_UNLOCK) &&
                    (&seen_reg) && patternOk;

  // trigger timer; fixed length in system clocks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trigger_reg <= 1'b0;
      timer_reg   <= '0;
      seen_reg    <= '0;
    end else if (!trigger_reg) begin
      if (wrCtl && regWdata[CTL_TRIGGER_BIT]) begin
        trigger_reg <= 1'b1;
        timer_reg   <= '0;
        seen_reg    <= '0;
      end
    end else begin
      timer_reg <= timer_reg + 1'b1;
      seen_reg  <= seen_reg | {wrHi[3], wrHi[2], wrHi[1],
                               wrLo[3], wrLo[2], wrLo[1]};
      if (timer_reg == TMR_LAST) begin
        trigger_reg <= 1'b0;
      end
    end
  end

  // software write of one has no effect; hardware set wins over clear
  // software zero drops erase/write capability at once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enabled_reg <= 1'b0;
    end else if (unlockOk) begin
      enabled_reg <= 1'b1;
    end else if (wrCtl && !regWdata[CTL_ENABLED_BIT]) begin
      enabled_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // plain control fields
  // --------------------------------------------------------------------------
  // all fields start at zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= 3'h0;
      gate_reg <= 1'b0;
      key_reg  <= RESET_BYTE;
      rsvd_reg <= 1'b0;
    end else begin
      if (wrCtl) begin
        mode_reg <= newMode;
        gate_reg <= regWdata[CTL_GATE_BIT];
      end
      if (wrKey) begin
        key_reg <= regWdata;
      end
      if (wrBuf) begin
        rsvd_reg <= regWdata[BUF_RSVD_BIT];
      end
    end
  end

  // key match gives a one-cycle chip reset request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chipResetReq_reg <= 1'b0;
    end else begin
      chipResetReq_reg <= wrKey && (regWdata == CHIP_RESET_KEY);
    end
  end

  // --------------------------------------------------------------------------
  // address and data registers
  // --------------------------------------------------------------------------
  // fourteen-bit address; bump stops at page end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_reg <= '0;
    end else if (wrAddrL) begin
      addr_reg[7:0] <= regWdata;
    end else if (wrAddrH) begin
      addr_reg[ADDR_W-1:8] <= regWdata[5:0];
    end else if (wrHi[0] && addr_reg[WIDX_W-1:0] != LAST_WORD) begin
      addr_reg <= addr_reg + 1'b1;
    end
  end

  // read result lands in word0; plain byte stores otherwise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int w = 0; w < DATA_WORDS; w++) begin
        dataLo_reg[w] <= RESET_BYTE;
        dataHi_reg[w] <= RESET_BYTE;
      end
    end else begin
      for (int w = 0; w < DATA_WORDS; w++) begin
        if (w == 0 && readDone) begin
          dataLo_reg[w] <= flashRdata[7:0];
          dataHi_reg[w] <= flashRdata[15:8];
        end else begin
          if (wrLo[w]) dataLo_reg[w] <= regWdata;
          if (wrHi[w]) dataHi_reg[w] <= regWdata;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // write buffer
  // --------------------------------------------------------------------------
  // high byte write loads the full word, only once unlocked
  assign bufWrEn = wrHi[0] && enabled_reg && (state_reg == ST_IDLE);
  // software clear; automatic clear after the last programmed word
  assign bufClrStart = (wrBuf && regWdata[BUF_CLEAR_BIT]) || progLast;

  fsp_write_buffer #(
    .DEPTH (PAGE_WORDS),
    .WIDTH (WORD_W),
    .IDX_W (WIDX_W)
  ) u_buffer (
    .clk      (clk),
    .resetn   (resetn),
    .wrEn     (bufWrEn),
    .wrIdx    (addr_reg[WIDX_W-1:0]),
    .wrData   ({regWdata, dataLo_reg[0]}),
    .clrStart (bufClrStart),
    .rdIdx    (wordIdx_reg),
    .rdData   (bufRdData),
    .clrBusy  (bufBusy),
    .clrDone  (bufDone)
  );

  // --------------------------------------------------------------------------
  // operation launch and sequencing
  // --------------------------------------------------------------------------
  // only listed codes launch; needs the flag kept in this write
  assign launchErase = wrCtl && state_reg == ST_IDLE && !bufBusy &&
                       regWdata[CTL_PROGRAM_BIT] && enabled_reg &&
                       regWdata[CTL_ENABLED_BIT] &&
                       isMode(newMode, MODE_ERASE);
  assign launchProg  = wrCtl && state_reg == ST_IDLE && !bufBusy &&
                       regWdata[CTL_PROGRAM_BIT] && enabled_reg &&
                       regWdata[CTL_ENABLED_BIT] &&
                       isMode(newMode, MODE_WRITE);
  // gate must already be set before this write
  assign launchRead  = wrCtl && state_reg == ST_IDLE && !bufBusy &&
                       regWdata[CTL_READ_BIT] && gate_reg &&
                       isMode(newMode, MODE_READ);
  assign readDone = (state_reg == ST_READ) && flashDone;
  assign progLast = (state_reg == ST_PWAIT) && flashDone &&
                    (wordIdx_reg == LAST_WORD);
  assign opBusy   = (state_reg == ST_ERASE) || (state_reg == ST_PLOAD) ||
                    (state_reg == ST_PWAIT) || (state_reg == ST_PCLEAR);

  // program_start reads one until done; stall while running
  // erase and program address the page of bits 13..5
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg        <= ST_IDLE;
      wordIdx_reg      <= '0;
      cpuStall_reg     <= 1'b0;
      flashErase_reg   <= 1'b0;
      flashProgram_reg <= 1'b0;
      flashRead_reg    <= 1'b0;
      flashAddr_reg    <= '0;
      flashWdata_reg   <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (launchErase) begin
            state_reg      <= ST_ERASE;
            flashErase_reg <= 1'b1;
            flashAddr_reg  <= {addr_reg[ADDR_W-1:PAGE_LSB], 5'h00};
            cpuStall_reg   <= 1'b1;
          end else if (launchProg) begin
            state_reg    <= ST_PLOAD;
            wordIdx_reg  <= '0;
            cpuStall_reg <= 1'b1;
          end else if (launchRead) begin
            state_reg     <= ST_READ;
            flashRead_reg <= 1'b1;
            flashAddr_reg <= addr_reg;
            cpuStall_reg  <= 1'b1;
          end
        end
        ST_ERASE: begin
          if (flashDone) begin
            state_reg      <= ST_IDLE;
            flashErase_reg <= 1'b0;
            cpuStall_reg   <= 1'b0;
          end
        end
        ST_PLOAD: begin
          state_reg        <= ST_PWAIT;
          flashProgram_reg <= 1'b1;
          flashWdata_reg   <= bufRdData;
          flashAddr_reg    <= {addr_reg[ADDR_W-1:PAGE_LSB], wordIdx_reg};
        end
        ST_PWAIT: begin
          if (flashDone) begin
            flashProgram_reg <= 1'b0;
            if (wordIdx_reg == LAST_WORD) begin
              state_reg <= ST_PCLEAR;
            end else begin
              wordIdx_reg <= wordIdx_reg + 1'b1;
              state_reg   <= ST_PLOAD;
            end
          end
        end
        ST_PCLEAR: begin
          // stay stalled until the buffer is blank again
          if (bufDone) begin
            state_reg    <= ST_IDLE;
            cpuStall_reg <= 1'b0;
          end
        end
        ST_READ: begin
          if (flashDone) begin
            state_reg     <= ST_IDLE;
            flashRead_reg <= 1'b0;
            cpuStall_reg  <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // read-back
  // --------------------------------------------------------------------------
  // unimplemented upper bits read zero
  always_comb begin
    rdMux = 8'h00;
    case (regAddr)
      REG_FLASH_CONTROL:  rdMux = {enabled_reg, mode_reg, trigger_reg, opBusy,
                                   gate_reg, state_reg == ST_READ};
      REG_CHIP_RESET_KEY: rdMux = key_reg;
      REG_BUFFER_CONTROL: rdMux = {6'h00, rsvd_reg, bufBusy};
      REG_ADDR_LOW:       rdMux = addr_reg[7:0];
      REG_ADDR_HIGH:      rdMux = {2'h0, addr_reg[ADDR_W-1:8]};
      default: begin
        for (int w = 0; w < DATA_WORDS; w++) begin
          if (regAddr == 4'(REG_DATA0_LOW + 2 * w)) rdMux = dataLo_reg[w];
          if (regAddr == 4'(REG_DATA0_LOW + 2 * w + 1)) rdMux = dataHi_reg[w];
        end
      end
    endcase
  end

  // read data registered, valid one clock after the address
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdata_reg <= 8'h00;
    end else begin
      regRdata_reg <= rdMux;
    end
  end

  assign regRdata     = regRdata_reg;
  assign cpuStall     = cpuStall_reg;
  assign chipResetReq = chipResetReq_reg;
  assign flashErase   = flashErase_reg;
  assign flashProgram = flashProgram_reg;
  assign flashRead    = flashRead_reg;
  assign flashAddr    = flashAddr_reg;
  assign flashWdata   = flashWdata_reg;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  flag_set_cause_a: assert property ($rose(enabled_reg) |->
    $past(unlockOk)) else $error("enabled flag set without unlock");
  flag_clear_a: assert property (wrCtl && !regWdata[CTL_ENABLED_BIT] &&
    !unlockOk |=> !enabled_reg && !flashErase && !flashProgram)
    else $error("flag clear did not disable");
  erase_mode_a: assert property ($rose(flashErase) |->
    $past(isMode(newMode, MODE_ERASE) && enabled_reg))
    else $error("erase without erase mode");
  reserved_mode_a: assert property (wrCtl && state_reg == ST_IDLE &&
    (newMode == 3'h2 || newMode[2] && newMode != MODE_UNLOCK) |=>
    state_reg == ST_IDLE) else $error("reserved code launched");
  timer_expire_a: assert property ($fell(trigger_reg) |->
    $past(timer_reg) == TMR_LAST) else $error("trigger cleared off time");
  read_gate_a: assert property (wrCtl && !gate_reg |=>
    !flashRead) else $error("read started with gate clear");
  read_result_a: assert property (readDone |=>
    {dataHi_reg[0], dataLo_reg[0]} == $past(flashRdata) && !cpuStall)
    else $error("read word not captured");
  stall_op_a: assert property (flashErase || flashProgram ||
    flashRead |-> cpuStall) else $error("operation running without stall");
  chip_reset_a: assert property (wrKey && regWdata == CHIP_RESET_KEY |=>
    chipResetReq ##1 !chipResetReq) else $error("chip reset pulse wrong");
  addr_step_a: assert property (wrHi[0] && !wrAddrL && !wrAddrH |=>
    addr_reg == ($past(addr_reg[WIDX_W-1:0]) == LAST_WORD ?
    $past(addr_reg) : $past(addr_reg) + 14'h0001))
    else $error("address step wrong");
  auto_clear_a: assert property (progLast |=> bufBusy)
    else $error("buffer not cleared after program");

  unlock_c: cover property ($rose(enabled_reg));
  program_c: cover property (progLast ##[1:40] state_reg == ST_IDLE);
  read_c: cover property (readDone);
  erase_c: cover property ($fell(flashErase));

endmodule

// file: verif/fsp_flash_model.sv
// flash array stand-in answering erase, program and read requests
module fsp_flash_model #(
  parameter int LAT = 4
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        flashErase,
  input  wire logic        flashProgram,
  input  wire logic        flashRead,
  input  wire logic [13:0] flashAddr,
  output logic             flashDone,
  output logic      [15:0] flashRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt;
  logic req;
  assign req = flashErase | flashProgram | flashRead;
  // one done pulse per request after a fixed wait, none while idle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      flashDone <= 1'b0;
    end else begin
      flashDone <= req && !flashDone && cnt == LAT - 1;
      cnt <= (req && !flashDone) ? cnt + 1 : 0;
    end
  end
  // word valid only with done; inverted outside so stale reads show
  assign flashRdata = {2'b00, flashAddr} ^ (flashDone ? 16'ha5a5 : 16'h5a5a);
endmodule

// file: verif/fsp_ctrl_tb_top.sv
// register-level tests of the flash self-programming controller
module fsp_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, resetn, regWrite, cpuStall, chipResetReq, flashDone;
  logic        flashErase, flashProgram, flashRead;
  logic [3:0]  regAddr;
  logic [7:0]  regWdata, regRdata;
  logic [13:0] flashAddr;
  logic [15:0] flashWdata, flashRdata, seenW;
  int          err_total, n_checks, i, n;
  logic [7:0]  pat [6] = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, 8'h40};
  fsp_ctrl #(.UNLOCK_CYCLES(16)) fsp_ctrl_inst (.clk(clk), .resetn(resetn),
    .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
    .regRdata(regRdata), .cpuStall(cpuStall), .chipResetReq(chipResetReq),
    .flashErase(flashErase), .flashProgram(flashProgram),
    .flashRead(flashRead), .flashAddr(flashAddr), .flashWdata(flashWdata),
    .flashDone(flashDone), .flashRdata(flashRdata));
  fsp_flash_model fsp_flash_model_inst (.clk(clk), .resetn(resetn),
    .flashErase(flashErase), .flashProgram(flashProgram),
    .flashRead(flashRead), .flashAddr(flashAddr), .flashDone(flashDone),
    .flashRdata(flashRdata));
  // ---------------------------------------------------------------
  // clock, word capture at the page's last slot, tasks
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (flashProgram && flashDone && flashAddr[4:0] == 5'h1f)
      seenW <= flashWdata;
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // registered read: answer lands one cycle after the index
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    @(posedge clk);
    #1 chk($sformatf("reg%0d", a), {8'h00, regRdata}, {8'h00, e});
  endtask
  // bounded wait, the array model answers within a few cycles per word
  task automatic idle;
    #1; // a launch taken in this very edge must show its stall first
    for (int k = 0; k < 3000 && cpuStall !== 1'b0; k++) @(posedge clk);
    chk("stallEnd", {15'h0000, cpuStall}, 16'h0000);
  endtask
  task automatic unlock(input logic [7:0] flip);
    wr(0, 8'h68);
    for (int k = 0; k < 6; k++)
      wr(4'(7 + k), pat[k] ^ (k == 5 ? flip : 8'h00));
    repeat (20) @(posedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog far beyond the several hundred cycles the tests need
  initial begin
    #100000;
    err_total++;
    close_out();
  end
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    regWrite = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (i = 0; i < 14; i++) rd(i[3:0], 8'h00);
    wr(0, 8'h80);
    rd(0, 8'h00);
    wr(4, 8'hff);
    rd(4, 8'h3f);
    wr(2, 8'hfc);
    rd(2, 8'h00);
    wr(1, 8'h55);
    n = 0;
    repeat (3) @(posedge clk) n += int'(chipResetReq);
    chk("chipReset", 16'(n), 16'h0001);
    $display("register test done");
    wr(3, 8'h45);
    wr(4, 8'h12);
    wr(0, 8'h31);
    rd(0, 8'h30);
    wr(0, 8'h32);
    wr(0, 8'h33); // gate came from the write before
    @(posedge clk);
    #1 chk("stall", {15'h0000, cpuStall}, 16'h0001);
    idle();
    rd(5, 8'he0);
    rd(6, 8'hb7);
    rd(0, 8'h32);
    for (i = 2; i < 8; i++) if (i != 3 && i != 6) begin
      wr(0, {1'b0, i[2:0], 4'h3});
      rd(0, {1'b0, i[2:0], 4'h2});
    end
    $display("read test done");
    unlock(8'h01);
    rd(0, 8'h60);
    wr(0, 8'h94);
    rd(0, 8'h10);
    unlock(8'h00);
    rd(0, 8'he0);
    $display("unlock test done");
    wr(3, 8'h1e);
    wr(5, 8'h34);
    wr(6, 8'h12);
    rd(3, 8'h1f);
    wr(5, 8'h78);
    wr(6, 8'h56);
    rd(3, 8'h1f);
    rd(5, 8'h78);
    // sub clock taken as stable; the array model has none
    wr(0, 8'h94);
    repeat (2) @(posedge clk);
    #1 chk("erase", {cpuStall, flashErase}, 16'h0003);
    chk("eraseAddr", {2'b00, flashAddr}, 16'h1200);
    idle();
    rd(0, 8'h90);
    wr(0, 8'h84);
    idle();
    rd(0, 8'h80);
    chk("lastWord", seenW, 16'h5678);
    wr(0, 8'h84);
    idle();
    chk("clearedWord", seenW, 16'h0000);
    wr(0, 8'h04);
    rd(0, 8'h00);
    wr(0, 8'h84);
    rd(0, 8'h00);
    chk("noProgram", {15'h0000, flashProgram}, 16'h0000);
    wr(2, 8'h01);
    rd(2, 8'h01);
    repeat (40) @(posedge clk);
    rd(2, 8'h00);
    $display("program test done");
    close_out();
  end
endmodule
